/* verilog/ltx_port.sv */
// ltx_port: parallel source-synchronous transmit port with paired-entry fifo
// assumes: mclk at 20 MHz, core writes on mclk, src_clk asynchronous, axi4-lite master
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module ltx_port (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // core write stream
    input wire logic wr_valid,
    input wire logic [31:0] wr_data,
    input wire logic [3:0] wr_tag,
    // fifo and lock status to the core
    output logic fifo_almost_empty,
    output logic fifo_almost_full,
    output logic fifo_empty,
    output logic fifo_overflow,
    output logic fifo_underflow,
    output logic pll_lock,
    // link
    input wire logic src_clk,
    output logic [15:0] tx_data,
    output logic tx_tag,
    output logic tx_clk,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == ltx_pkg::OFS_CTRL) || (a == ltx_pkg::OFS_PAT_ST) ||
            (a == ltx_pkg::OFS_PAT_UF) || (a == ltx_pkg::OFS_WMARK) ||
            (a == ltx_pkg::OFS_DIV) || (a == ltx_pkg::OFS_STAT);
    endfunction : is_mapped

    function automatic logic [31:0] arrange(input logic [31:0] w, input logic bys,
        input logic bis);
        logic [31:0] t;
        t = bys ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
        arrange = t;
        if (bis) begin
            for (int i = 0; i < 32; i++) begin
                arrange[i] = t[(i & ~7) + 7 - (i & 7)];
            end
        end
    endfunction : arrange

    function automatic logic [31:0] strb_merge(input logic [31:0] o, input logic [31:0] n,
        input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            strb_merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
    endfunction : strb_merge

    // registers
    logic [31:0] ctrl_r, pat_st_r, pat_uf_r, wmark_r, div_r;
    logic flush_r, warm_r, ovf_clr;
    // axi state
    logic [7:0] awaddr_r, araddr_nxt;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_full_r, w_full_r, do_wr;
    // fifo
    logic [ltx_pkg::ENT_W-1:0] mem_r [ltx_pkg::WORDS];
    logic [ltx_pkg::ENT_W-1:0] pend_r, head;
    logic pend_v_r, started_r;
    logic [ltx_pkg::PTR_W-1:0] wp_r, rp_r, words;
    logic [ltx_pkg::PTR_W-1:0] lvl8;
    logic [ltx_pkg::LVL_W-1:0] lvl;
    logic full_now, wr_in, wr_pair, wr_drop, clr_fifo;
    // link timing
    logic src_s1_r, src_s2_r, src_s3_r, src_rise;
    logic [7:0] per_cnt_r, period_r, tick_cnt_r, interval;
    logic [2:0] mult_act_r, lk_cnt_r;
    logic [1:0] ph_r, ph_nxt, sl_r;
    logic run, tick, launch, last_sl, rate_err_r;
    logic [31:0] word;
    logic [15:0] slice;
    logic slice_tag;

    wire pd = ctrl_r[ltx_pkg::C_PD];
    wire ddr = ctrl_r[ltx_pkg::C_DDR];
    wire w8 = ctrl_r[ltx_pkg::C_W8];

    // ---------------- axi4-lite slave
    assign do_wr = aw_full_r && w_full_r && !s_axi_bvalid;

    always_ff @(posedge mclk) begin
        if (rst) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_full_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (do_wr) begin
                w_full_r <= 1'b0;
            end
            s_axi_awready <= s_axi_awready ? !s_axi_awvalid :
                (!aw_full_r && !s_axi_bvalid && !do_wr);
            s_axi_wready <= s_axi_wready ? !s_axi_wvalid :
                (!w_full_r && !s_axi_bvalid && !do_wr);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ltx_pkg::RESP_OK;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(awaddr_r) ? ltx_pkg::RESP_OK : ltx_pkg::RESP_ERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // register writes; flush and warm reset are one-cycle pulses
    assign ovf_clr = do_wr && awaddr_r == ltx_pkg::OFS_STAT && wstrb_r[0] &&
        wdata_r[ltx_pkg::S_OVF];

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_r <= ltx_pkg::CTRL_RST;
            pat_st_r <= ltx_pkg::PAT_ST_RST;
            pat_uf_r <= ltx_pkg::PAT_UF_RST;
            wmark_r <= ltx_pkg::WMARK_RST;
            div_r <= ltx_pkg::DIV_RST;
            flush_r <= 1'b0;
            warm_r <= 1'b0;
        end else begin
            flush_r <= do_wr && awaddr_r == ltx_pkg::OFS_CTRL && wstrb_r[2] &&
                wdata_r[ltx_pkg::C_FLUSH];
            warm_r <= do_wr && awaddr_r == ltx_pkg::OFS_CTRL && wstrb_r[2] &&
                wdata_r[ltx_pkg::C_WARM];
            if (do_wr) begin
                unique case (awaddr_r)
                    ltx_pkg::OFS_CTRL: ctrl_r <= strb_merge(ctrl_r, wdata_r, wstrb_r) &
                        ltx_pkg::CTRL_MASK;
                    ltx_pkg::OFS_PAT_ST: pat_st_r <= strb_merge(pat_st_r, wdata_r, wstrb_r) &
                        32'h0001_ffff;
                    ltx_pkg::OFS_PAT_UF: pat_uf_r <= strb_merge(pat_uf_r, wdata_r, wstrb_r) &
                        32'h0001_ffff;
                    ltx_pkg::OFS_WMARK: wmark_r <= strb_merge(wmark_r, wdata_r, wstrb_r) &
                        32'hff7f_007f;
                    ltx_pkg::OFS_DIV: div_r <= strb_merge(div_r, wdata_r, wstrb_r) &
                        32'h0000_00ff;
                    default: ;
                endcase
            end
        end
    end

    // reads: one outstanding, data registered with the valid
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ltx_pkg::RESP_OK;
        end else begin
            s_axi_arready <= s_axi_arready ? !s_axi_arvalid : !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= is_mapped(s_axi_araddr) ? ltx_pkg::RESP_OK : ltx_pkg::RESP_ERR;
                unique case (s_axi_araddr)
                    ltx_pkg::OFS_CTRL: s_axi_rdata <= ctrl_r;
                    ltx_pkg::OFS_PAT_ST: s_axi_rdata <= pat_st_r;
                    ltx_pkg::OFS_PAT_UF: s_axi_rdata <= pat_uf_r;
                    ltx_pkg::OFS_WMARK: s_axi_rdata <= wmark_r;
                    ltx_pkg::OFS_DIV: s_axi_rdata <= div_r;
                    ltx_pkg::OFS_STAT: s_axi_rdata <= {9'h000, lvl, 8'h00, rate_err_r,
                        started_r, pll_lock, fifo_underflow, fifo_overflow, fifo_empty,
                        fifo_almost_full, fifo_almost_empty};
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ---------------- paired-entry fifo
    assign clr_fifo = flush_r || warm_r;
    assign words = wp_r - rp_r;
    assign lvl8 = (words + 8'h01) >> 1;
    assign lvl = lvl8[ltx_pkg::LVL_W-1:0];
    assign full_now = words > ltx_pkg::FULL_WORDS;
    assign wr_in = wr_valid && !pd && !clr_fifo;
    assign wr_pair = wr_in && pend_v_r && !full_now;
    assign wr_drop = wr_in && pend_v_r && full_now;

    // a lone write waits here; its partner carries both into the fifo
    always_ff @(posedge mclk) begin
        if (rst) begin
            pend_v_r <= 1'b0;
            pend_r <= '0;
        end else if (clr_fifo) begin
            pend_v_r <= 1'b0;
        end else if (wr_in && !pend_v_r) begin
            pend_v_r <= 1'b1;
            pend_r <= {wr_tag, wr_data};
        end else if (wr_pair) begin
            pend_v_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (wr_pair) begin
            mem_r[wp_r[6:0]] <= pend_r;
            mem_r[7'(wp_r[6:0] + 7'h01)] <= {wr_tag, wr_data};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wp_r <= '0;
        end else if (wr_pair) begin
            wp_r <= wp_r + 8'h02;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            started_r <= 1'b0;
        end else if (warm_r) begin
            started_r <= 1'b0;
        end else if (wr_pair) begin
            started_r <= 1'b1;
        end
    end

    // status flags come from registered pointers, so they never glitch
    always_ff @(posedge mclk) begin
        if (rst) begin
            fifo_almost_empty <= 1'b1;
            fifo_almost_full <= 1'b0;
            fifo_empty <= 1'b1;
            fifo_overflow <= 1'b0;
        end else begin
            fifo_almost_empty <= lvl < wmark_r[ltx_pkg::W_AE +: ltx_pkg::LVL_W];
            fifo_almost_full <= lvl > wmark_r[ltx_pkg::W_AF +: ltx_pkg::LVL_W];
            fifo_empty <= words == 8'h00;
            if (wr_drop) begin
                fifo_overflow <= 1'b1;
            end else if (ovf_clr) begin
                fifo_overflow <= 1'b0;
            end
        end
    end

    // ---------------- transmit clock source and lock
    always_ff @(posedge mclk) begin
        if (rst) begin
            src_s1_r <= 1'b0;
            src_s2_r <= 1'b0;
            src_s3_r <= 1'b0;
        end else begin
            src_s1_r <= src_clk;
            src_s2_r <= src_s1_r;
            src_s3_r <= src_s2_r;
        end
    end
    assign src_rise = src_s2_r && !src_s3_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            per_cnt_r <= 8'h00;
            period_r <= 8'h00;
        end else if (src_rise) begin
            per_cnt_r <= 8'h01;
            period_r <= per_cnt_r;
        end else if (per_cnt_r != 8'hff) begin
            per_cnt_r <= per_cnt_r + 8'h01;
        end
    end

    // the multiplier takes effect through a warm reset or while powered down
    always_ff @(posedge mclk) begin
        if (rst) begin
            mult_act_r <= ltx_pkg::CTRL_RST[ltx_pkg::C_MULT +: 3];
            lk_cnt_r <= 3'h0;
            pll_lock <= 1'b0;
        end else if (warm_r || pd) begin
            mult_act_r <= ctrl_r[ltx_pkg::C_MULT +: 3];
            lk_cnt_r <= 3'h0;
            pll_lock <= 1'b0;
        end else if (!ctrl_r[ltx_pkg::C_SRC]) begin
            pll_lock <= 1'b1;
        end else if (src_rise && lk_cnt_r != ltx_pkg::LOCK_EDGES) begin
            lk_cnt_r <= lk_cnt_r + 3'h1;
        end else if (lk_cnt_r == ltx_pkg::LOCK_EDGES) begin
            pll_lock <= 1'b1;
        end
    end

    // out-of-range settings are reported only: mclk cannot itself reach the range
    always_ff @(posedge mclk) begin
        if (rst) begin
            rate_err_r <= 1'b0;
        end else if (ctrl_r[ltx_pkg::C_SRC]) begin
            rate_err_r <= mult_act_r > ltx_pkg::MULT_MAX ||
                (ltx_pkg::SRC_MAX_KHZ << mult_act_r) > (ddr ? ltx_pkg::TX_MAX_DDR_KHZ :
                ltx_pkg::TX_MAX_SDR_KHZ);
        end else begin
            rate_err_r <= ltx_pkg::MCLK_KHZ < ltx_pkg::TX_MIN_KHZ * 4 * int'(div_r[7:0]);
        end
    end

    // four phase ticks per transmit clock period
    always_comb begin
        interval = period_r >> (3'(mult_act_r) + 3'h2);
        if (!ctrl_r[ltx_pkg::C_SRC]) begin
            interval = div_r[7:0];
        end
        if (interval == 8'h00) begin
            interval = 8'h01;
        end
    end
    assign run = !pd && pll_lock && !warm_r;
    assign tick = run && tick_cnt_r == 8'h00;

    always_ff @(posedge mclk) begin
        if (rst) begin
            tick_cnt_r <= 8'h00;
        end else if (!run) begin
            tick_cnt_r <= 8'h00;
        end else begin
            tick_cnt_r <= tick ? interval - 8'h01 : tick_cnt_r - 8'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ph_r <= 2'h0;
        end else if (!run) begin
            ph_r <= 2'h0;
        end else if (tick) begin
            ph_r <= ph_nxt;
        end
    end
    assign ph_nxt = ph_r + 2'h1;
    assign launch = tick && (ddr ? !ph_nxt[0] : ph_nxt == 2'h0);

    // ---------------- serializer
    assign head = mem_r[rp_r[6:0]];
    assign word = arrange(head[31:0], ctrl_r[ltx_pkg::C_BYTESW], ctrl_r[ltx_pkg::C_BITSW]);
    assign last_sl = sl_r == (w8 ? 2'h3 : 2'h1);
    always_comb begin
        slice = word[sl_r[0]*16 +: 16];
        slice_tag = head[32 + sl_r];
        if (w8) begin
            slice[7:0] = word[sl_r*8 +: 8];
            slice[15:8] = ctrl_r[ltx_pkg::C_FILLC] ? wmark_r[ltx_pkg::W_FILL +: 8] :
                word[sl_r*8 +: 8];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rp_r <= '0;
            sl_r <= 2'h0;
        end else if (clr_fifo) begin
            rp_r <= wp_r;
            sl_r <= 2'h0;
        end else if (launch && words != 8'h00) begin
            sl_r <= last_sl ? 2'h0 : sl_r + 2'h1;
            if (last_sl) begin
                rp_r <= rp_r + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_data <= 16'h0000;
            tx_tag <= 1'b0;
            tx_clk <= 1'b0;
            fifo_underflow <= 1'b0;
        end else if (!run) begin
            tx_data <= 16'h0000;
            tx_tag <= 1'b0;
            tx_clk <= 1'b0;
        end else begin
            if (tick) begin
                tx_clk <= ctrl_r[ltx_pkg::C_CLK90] ? ph_nxt[1] ^ ph_nxt[0] : ph_nxt[1];
            end
            if (launch && words != 8'h00) begin
                {tx_tag, tx_data} <= {slice_tag, slice};
                fifo_underflow <= 1'b0;
            end else if (launch && started_r) begin
                {tx_tag, tx_data} <= pat_uf_r[16:0];
                fifo_underflow <= 1'b1;
            end else if (launch) begin
                {tx_tag, tx_data} <= pat_st_r[16:0];
            end
        end
    end

    // ---------------- checks
    property p_empty;
        @(posedge mclk) disable iff (rst)
        ##1 fifo_empty == ($past(wp_r) == $past(rp_r));
    endproperty
    a_empty: assert property (p_empty) else $error("empty flag disagrees with pointers");

    property p_ovf;
        @(posedge mclk) disable iff (rst)
        wr_in && pend_v_r && full_now |=> fifo_overflow && $stable(wp_r);
    endproperty
    a_ovf: assert property (p_ovf) else $error("write to full fifo not dropped");

    property p_lone;
        @(posedge mclk) disable iff (rst)
        wr_in && !pend_v_r |=> pend_v_r && $stable(wp_r);
    endproperty
    a_lone: assert property (p_lone) else $error("lone write entered fifo");

    property p_pair;
        @(posedge mclk) disable iff (rst)
        wr_pair |=> wp_r == $past(wp_r) + 8'h02 && started_r;
    endproperty
    a_pair: assert property (p_pair) else $error("pair not stored");

    property p_depth;
        @(posedge mclk) disable iff (rst)
        words <= 8'(ltx_pkg::WORDS);
    endproperty
    a_depth: assert property (p_depth) else $error("fifo beyond 64 pairs");

    property p_startup;
        @(posedge mclk) disable iff (rst)
        launch && run && !started_r && words == 8'h00 && !clr_fifo
        |=> {tx_tag, tx_data} == $past(pat_st_r[16:0]);
    endproperty
    a_startup: assert property (p_startup) else $error("startup pattern missing");

    property p_udf;
        @(posedge mclk) disable iff (rst)
        launch && run && started_r && words == 8'h00 && !clr_fifo
        |=> fifo_underflow && {tx_tag, tx_data} == $past(pat_uf_r[16:0]);
    endproperty
    a_udf: assert property (p_udf) else $error("underflow pattern or flag missing");

    property p_flush;
        @(posedge mclk) disable iff (rst)
        flush_r |=> rp_r == $past(wp_r) && !pend_v_r;
    endproperty
    a_flush: assert property (p_flush) else $error("flush left entries");

    property p_pd;
        @(posedge mclk) disable iff (rst)
        pd ##1 pd |-> !tx_clk && tx_data == 16'h0000 && !pll_lock;
    endproperty
    a_pd: assert property (p_pd) else $error("powered-down port is active");

    property p_warm;
        @(posedge mclk) disable iff (rst)
        warm_r |=> !pll_lock && mult_act_r == $past(ctrl_r[ltx_pkg::C_MULT +: 3]);
    endproperty
    a_warm: assert property (p_warm) else $error("warm reset kept lock");

    property p_wresp;
        @(posedge mclk) disable iff (rst)
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
        |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wresp: assert property (p_wresp) else $error("write response late");
endmodule : ltx_port

/* pkg/ltx_pkg.sv */
// ltx_pkg: shared constants of the parallel transmit port
// assumes: compiled before the port module; users name items as ltx_pkg::name
package ltx_pkg;
    // widths and depths
    localparam int DATA_W = 32;
    localparam int TAG_W = 4;
    localparam int ENT_W = DATA_W + TAG_W;
    localparam int PIN_W = 16;
    localparam int PAIRS = 64;
    localparam int WORDS = 2 * PAIRS;
    localparam int PTR_W = 8;
    localparam int LVL_W = 7;
    localparam logic [PTR_W-1:0] FULL_WORDS = 8'h7e;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PAT_ST = 8'h04;
    localparam logic [7:0] OFS_PAT_UF = 8'h08;
    localparam logic [7:0] OFS_WMARK = 8'h0c;
    localparam logic [7:0] OFS_DIV = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    // control fields
    localparam int C_PD = 0;
    localparam int C_DDR = 1;
    localparam int C_W8 = 2;
    localparam int C_BYTESW = 3;
    localparam int C_BITSW = 4;
    localparam int C_FILLC = 5;
    localparam int C_CLK90 = 6;
    localparam int C_SRC = 7;
    localparam int C_MULT = 8;
    localparam int C_FLUSH = 16;
    localparam int C_WARM = 17;
    localparam logic [31:0] CTRL_MASK = 32'h0000_07ff;
    // watermark fields
    localparam int W_AE = 0;
    localparam int W_AF = 16;
    localparam int W_FILL = 24;
    // status fields
    localparam int S_AE = 0;
    localparam int S_AF = 1;
    localparam int S_EMPTY = 2;
    localparam int S_OVF = 3;
    localparam int S_UDF = 4;
    localparam int S_LOCK = 5;
    localparam int S_STARTED = 6;
    localparam int S_RATE = 7;
    localparam int S_LVL = 16;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] PAT_ST_RST = 32'h0000_0000;
    localparam logic [31:0] PAT_UF_RST = 32'h0000_0000;
    localparam logic [31:0] WMARK_RST = 32'h0038_0008;
    localparam logic [31:0] DIV_RST = 32'h0000_0001;
    // clock rates in kHz
    localparam int MCLK_KHZ = 20000;
    localparam int TX_MIN_KHZ = 18750;
    localparam int TX_MAX_DDR_KHZ = 500000;
    localparam int TX_MAX_SDR_KHZ = 640000;
    localparam int SRC_MAX_KHZ = 37500;
    localparam logic [2:0] MULT_MAX = 3'h5;
    // source edges seen before lock is reported
    localparam logic [2:0] LOCK_EDGES = 3'h4;
    // axi responses
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : ltx_pkg

/* verification/ltx_rx_model.sv */
// ltx_rx_model: far-side receiver of the link, plus the free-running source clock
// assumes: aligned forwarded clock, so its rising edge falls mid-slice
`timescale 1ns/1ps
module ltx_rx_model (
    // link
    input wire logic tx_clk,
    input wire logic tx_tag,
    input wire logic [15:0] tx_data,
    output logic src_clk
);
    logic [16:0] rx_q[$];
    // the source oscillator runs free, frames or not
    initial begin
        src_clk = 1'b0;
        forever #200 src_clk = ~src_clk;
    end
    always @(posedge tx_clk) rx_q.push_back({tx_tag, tx_data});
endmodule : ltx_rx_model

/* verification/tb_top.sv */
// tb_top: self-checking bench for the transmit port
// assumes: ltx_port and ltx_rx_model compiled, 20 MHz core clock
`timescale 1ns/1ps
module tb_top;
    localparam logic [16:0] ST = 17'h1a55a;
    localparam logic [16:0] UF = 17'h0c33c;
    logic mclk, rst, wr_valid, awv, wv, bre, arv, rre, src;
    logic ae, af, emp, ovf, udf, lck, tc, tt, awr, wr, bv, arr, rv;
    logic [31:0] wr_data, wd, rd, v;
    logic [3:0] wr_tag;
    logic [7:0] aw, ar;
    logic [15:0] td;
    logic [1:0] br, rr, r;
    int err_count, checked, cyc;
    ltx_port ltx_port_inst (.mclk(mclk), .rst(rst), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_tag(wr_tag), .fifo_almost_empty(ae),
        .fifo_almost_full(af), .fifo_empty(emp), .fifo_overflow(ovf),
        .fifo_underflow(udf), .pll_lock(lck), .src_clk(src), .tx_data(td),
        .tx_tag(tt), .tx_clk(tc), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ar),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
    ltx_rx_model ltx_rx_model_inst (.tx_clk(tc), .tx_tag(tt), .tx_data(td), .src_clk(src));
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task stop_test;
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // address and data offered together, each released when taken
    task axw(input logic [7:0] a, input logic [31:0] d);
        aw <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        fork
            begin do @(posedge mclk); while (!awr); awv <= 1'b0; end
            begin do @(posedge mclk); while (!wr); wv <= 1'b0; end
        join
        bre <= 1'b1;
        do @(posedge mclk); while (!bv);
        chk("bresp", br, 2'h0);
        bre <= 1'b0;
    endtask : axw
    task axr(input logic [7:0] a);
        ar <= a;
        arv <= 1'b1;
        do @(posedge mclk); while (!arr);
        arv <= 1'b0;
        rre <= 1'b1;
        do @(posedge mclk); while (!rv);
        v = rd;
        r = rr;
        rre <= 1'b0;
    endtask : axr
    function logic [16:0] slc(logic [31:0] w, logic [3:0] t, int n, logic bs);
        logic [31:0] x;
        x = bs ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
        return {t[n], (n == 0) ? x[15:0] : x[31:16]};
    endfunction : slc
    // one lone write, then its partner; slices must follow the idle pattern
    task pair(input logic bs, input logic [16:0] pat);
        logic [31:0] w[2];
        logic [3:0] t[2];
        int i;
        w = '{$urandom, $urandom};
        t = '{4'($urandom), 4'($urandom)};
        i = 0;
        wr_valid <= 1'b1;
        wr_data <= w[0];
        wr_tag <= t[0];
        @(posedge mclk);
        wr_valid <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("lone", emp, 1);
        ltx_rx_model_inst.rx_q.delete();
        wr_valid <= 1'b1;
        wr_data <= w[1];
        wr_tag <= t[1];
        @(posedge mclk);
        wr_valid <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("empty", emp, 0);
        while (ltx_rx_model_inst.rx_q.size() < 10) @(posedge mclk);
        while (ltx_rx_model_inst.rx_q[i] === pat) i++;
        for (int k = 0; k < 4; k++) begin
            chk("slice", ltx_rx_model_inst.rx_q[i+k], slc(w[k/2], t[k/2], k%2, bs));
        end
        chk("uf pat", ltx_rx_model_inst.rx_q[i+4], UF);
        chk("udf", udf, 1);
    endtask : pair
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // a hang counts as a mismatch
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            stop_test;
        end
    end
    initial begin
        {rst, wr_valid, wr_data, wr_tag, awv, wv, bre, arv, rre, aw, ar, wd} = '0;
        rst = 1'b1;
        void'($urandom(86));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        axr(8'h00);
        chk("ctrl rst", v, 32'h1);
        axr(8'hfc);
        chk("unmapped", r, 2'h2);
        chk("ae", ae, 1);
        axw(8'h04, ST);
        axw(8'h08, UF);
        axw(8'h00, 32'h0);
        while (!lck) @(posedge mclk);
        pair(1'b0, ST);
        axw(8'h00, 32'h8);
        pair(1'b1, UF);
        // slowest phase ticks, so the burst outruns the drain and fills the fifo
        axw(8'h10, 32'hff);
        wr_valid <= 1'b1;
        repeat (132) begin
            wr_data <= $urandom;
            @(posedge mclk);
        end
        wr_valid <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("ovf", ovf, 1);
        chk("af", af, 1);
        axw(8'h00, 32'h1_0000);
        repeat (4) @(posedge mclk);
        chk("flush", emp, 1);
        axw(8'h14, 32'h8);
        chk("ovf clr", ovf, 0);
        // source clock, multiplier x2, through a warm reset
        axw(8'h00, 32'h2_0180);
        @(posedge mclk);
        chk("warm", lck, 0);
        while (!lck) @(posedge mclk);
        stop_test;
    end
endmodule : tb_top
